// ### bus_ctrl_model.sv
// bus controller model: grants each bus request once after a set delay
`timescale 1ns/1ps
module bus_ctrl_model (
  input  wire logic       core_clk,
  input  wire logic       rst,
  input  wire logic       bus_request,
  input  wire logic [3:0] ack_delay,
  output logic            bus_ack
);
  logic [3:0] waited;
  logic       served;
  always_ff @(posedge core_clk) begin
    if (rst || !bus_request) begin
      waited <= 4'h0;
      served <= 1'b0;
      bus_ack <= 1'b0;
    end else begin
      // one acknowledge per request, even while it is held
      bus_ack <= !served && !bus_ack && waited >= ack_delay;
      served <= served | bus_ack;
      if (waited != 4'hF) begin
        waited <= waited + 4'h1;
      end
    end
  end
endmodule

// ### microword_control_decode.sv
// microword pipeline register and lower-field control decoder
//
// The register offsets and the Wishbone interface to the registers are this design's own decisions.
`timescale 1ns/1ps
// Behaviour
// (RULE1) bit 67 low drives status word onto ALU operand bus
// (RULE2) bit 66 low puts instruction bits 3..0 on sequencer direct input
// (RULE3) bit 65 low routes instruction bits 7..4 to status test select
// (RULE4) bits 64..60 drive pc unit function; 4,5,8,A3 zero; 6 copies 7
// (RULE5) bits 59..57 and 56..54 give pc unit A and B addresses
// (RULE6) bit 53 raises bus request a cycle ahead of memory use
// (RULE7) next microword halts until bus acknowledge arrives
// (RULE8) bit 52 raises a one-cycle memory request
// (RULE9) bit 51 low holds the bus request and keeps bus ownership
// (RULE10) bit 50 high means write, low means read
// (RULE11) bit 49 word or byte; address bit 0 picks the byte
// (RULE12) bit 48 low drives microword literal onto ALU operand bus
// (RULE13) bit 47 selects ALU addresses from microword or instruction
// (RULE14) bit 46 loads io control register from bits 42..35
// (RULE15) bit 45 stops interrupt recognition
// (RULE16) bit 44 enables interrupt command from bits 35..38
// (RULE17) bit 43 shift enable; shift controls from bits 35..39
// (RULE18) bits 42..35 shared field, meaning set by strobes 47..43
// (RULE19) bit 34 gates test result onto sequencer condition input
// (RULE20) test field evaluated in status unit and eight-input selector
// (RULE21) bits 19..16 drive sequencer instruction inputs
// (RULE22) bits 15..0 serve as branch address and literal
// (RULE23) idle ALU code forces zero output and writes nothing
// (RULE24) carry control field sets carry into lowest ALU slice
// (RULE25) bit 90 high runs byte mode, upper slices blocked
// (RULE26) pipeline register holds while a bus grant is awaited
// (RULE27) at most one source drives the ALU operand bus
module microword_control_decode #(
  parameter int UW = microword_pkg::UW_WIDTH
) (
  input  wire logic                 core_clk,
  input  wire logic                 rst,
  input  wire logic [UW-1:0]        microword_next,
  input  wire logic [15:0]          instr_reg,
  input  wire logic [15:0]          status_word,
  input  wire logic                 status_test_result,
  input  wire logic [7:0]           test_mux_inputs,
  input  wire logic                 status_carry,
  input  wire logic                 carry_pass_in,
  input  wire logic                 mem_addr_lsb,
  input  wire logic                 bus_ack,
  output logic                      pipe_advance,
  output logic [15:0]               operand_bus,
  output logic                      operand_bus_drive,
  output logic                      status_word_to_operand_n,
  output logic                      literal_to_operand_n,
  output logic                      shift_count_to_sequencer_n,
  output logic [15:0]               seq_direct_in,
  output logic                      branch_test_from_instr_n,
  output logic [3:0]                status_test_sel,
  output logic [8:0]                pc_unit_func_bits,
  output logic [3:0]                pc_unit_a_addr,
  output logic [3:0]                pc_unit_b_addr,
  output logic                      bus_request,
  output logic                      bus_hold_n,
  output logic                      memory_request,
  output logic                      mem_write,
  output logic                      mem_word_not_byte,
  output logic                      mem_byte_hi_sel,
  output logic                      mem_byte_lo_sel,
  output logic [3:0]                alu_a_addr,
  output logic [3:0]                alu_b_addr,
  output logic [8:0]                alu_ctrl,
  output logic                      alu_carry_in,
  output logic                      upper_slices_enable,
  output logic [7:0]                io_control,
  output logic                      io_control_load,
  output logic                      irq_recognition_disable,
  output logic                      irq_ctrl_cmd_enable,
  output logic [3:0]                irq_ctrl_cmd,
  output logic                      shift_link_enable,
  output logic [4:0]                shift_ctrl,
  output logic [7:0]                shared_control_field,
  output logic                      test_output_enable,
  output logic [5:0]                test_code,
  output logic [2:0]                test_mux_sel,
  output logic                      seq_condition,
  output logic [3:0]                next_address_control,
  input  wire logic                 wb_cyc_i,
  input  wire logic                 wb_stb_i,
  input  wire logic                 wb_we_i,
  input  wire logic [7:0]           wb_adr_i,
  input  wire logic [3:0]           wb_sel_i,
  input  wire logic [31:0]          wb_dat_i,
  output logic [31:0]               wb_dat_o,
  output logic                      wb_ack_o
);
  import microword_pkg::*;

  logic [UW-1:0] pipe;
  bus_state_t    bus_state;
  logic          stalled;
  logic          freeze;
  logic [31:0]   stall_count;
  logic [15:0]   literal;
  logic          addr_from_rom;
  logic [7:0]    addr_src;
  logic          wb_req;
  logic [31:0]   next_dat;

  assign literal = pipe[LIT_HI:0]; // RULE22

  // the word after a bus request waits here until acknowledge
  assign stalled      = (bus_state == BUS_WAIT) && !bus_ack; // RULE7
  assign pipe_advance = !stalled && !freeze;

  always_ff @(posedge core_clk) begin
    if (rst) begin
      pipe <= '0;
      pipe[BIT_STATUS_N]    <= 1'b1;
      pipe[BIT_SHIFT_CNT_N] <= 1'b1;
      pipe[BIT_BR_TEST_N]   <= 1'b1;
      pipe[BIT_HOLD_N]      <= 1'b1;
      pipe[BIT_LITERAL_N]   <= 1'b1;
      pipe[BIT_WORD]        <= 1'b1;
      pipe[ALU_CTRL_HI:ALU_CTRL_LO] <= ALU_IDLE_CTRL; // RULE23
    end else if (pipe_advance) begin // RULE26
      pipe <= microword_next;
    end
  end

  // bus ownership tracking
  always_ff @(posedge core_clk) begin
    if (rst) begin
      bus_state <= BUS_IDLE;
    end else begin
      case (bus_state)
        BUS_IDLE: begin
          if (pipe_advance && pipe[BIT_BUS_REQ]) begin
            bus_state <= BUS_WAIT; // RULE6
          end
        end
        BUS_WAIT: begin
          if (bus_ack) begin
            bus_state <= BUS_GRANTED;
          end
        end
        BUS_GRANTED: begin
          if (pipe_advance && pipe[BIT_BUS_REQ]) begin
            bus_state <= BUS_WAIT;
          end else if (pipe[BIT_HOLD_N]) begin
            bus_state <= BUS_IDLE; // RULE9
          end
        end
        default: bus_state <= BUS_IDLE;
      endcase
    end
  end

  assign bus_hold_n  = pipe[BIT_HOLD_N];
  assign bus_request = pipe[BIT_BUS_REQ] || (bus_state == BUS_WAIT) ||
                       (!pipe[BIT_HOLD_N] && bus_state == BUS_GRANTED); // RULE9

  assign memory_request    = pipe[BIT_MEM_REQ] && pipe_advance; // RULE8
  assign mem_write         = pipe[BIT_WRITE]; // RULE10
  assign mem_word_not_byte = pipe[BIT_WORD]; // RULE11
  assign mem_byte_hi_sel   = !pipe[BIT_WORD] && !mem_addr_lsb; // RULE11
  assign mem_byte_lo_sel   = !pipe[BIT_WORD] && mem_addr_lsb; // RULE11

  // operand bus: literal has priority over status word
  assign literal_to_operand_n     = pipe[BIT_LITERAL_N]; // RULE12
  assign status_word_to_operand_n = pipe[BIT_STATUS_N] ||
                                    !pipe[BIT_LITERAL_N]; // RULE27
  assign operand_bus_drive = !literal_to_operand_n ||
                             !status_word_to_operand_n;
  always_comb begin
    if (!literal_to_operand_n) begin
      operand_bus = literal; // RULE12
    end else if (!status_word_to_operand_n) begin
      operand_bus = status_word; // RULE1
    end else begin
      operand_bus = 16'h0000;
    end
  end

  assign shift_count_to_sequencer_n = pipe[BIT_SHIFT_CNT_N];
  assign seq_direct_in = pipe[BIT_SHIFT_CNT_N] ? literal :
                         {12'h000, instr_reg[3:0]}; // RULE2
  assign branch_test_from_instr_n = pipe[BIT_BR_TEST_N];
  assign status_test_sel = pipe[BIT_BR_TEST_N] ? pipe[TEST_LO+3:TEST_LO] :
                           instr_reg[7:4]; // RULE3

  assign pc_unit_func_bits = {1'b0, pipe[PCU_FUNC_HI], pipe[PCU_FUNC_HI],
                              2'b00, pipe[PCU_FUNC_HI-1:PCU_FUNC_LO]}; // RULE4
  assign pc_unit_a_addr = {1'b0, pipe[PCU_A_HI:PCU_A_LO]}; // RULE5
  assign pc_unit_b_addr = {1'b0, pipe[PCU_B_HI:PCU_B_LO]}; // RULE5

  // high selects the microword field, low the instruction register
  assign addr_from_rom = pipe[BIT_ADDR_FROM_ROM];
  assign addr_src   = addr_from_rom ? pipe[CTL_HI:CTL_LO] :
                      instr_reg[7:0]; // RULE13
  assign alu_a_addr = addr_src[3:0];
  assign alu_b_addr = addr_src[7:4];

  assign alu_ctrl            = pipe[ALU_CTRL_HI:ALU_CTRL_LO];
  assign upper_slices_enable = !pipe[BIT_BYTE_MODE]; // RULE25

  always_comb begin
    case (pipe[CARRY_HI:CARRY_LO])
      CARRY_ZERO:   alu_carry_in = 1'b0; // RULE24
      CARRY_ONE:    alu_carry_in = 1'b1;
      CARRY_PASS:   alu_carry_in = carry_pass_in;
      CARRY_STATUS: alu_carry_in = status_carry;
      default:      alu_carry_in = 1'b0;
    endcase
  end

  assign shared_control_field    = pipe[CTL_HI:CTL_LO]; // RULE18
  assign io_control_load         = pipe[BIT_IO_LOAD] && pipe_advance;
  assign irq_recognition_disable = pipe[BIT_IRQ_DIS]; // RULE15
  assign irq_ctrl_cmd_enable     = pipe[BIT_IRQ_CMD] && pipe_advance;
  assign irq_ctrl_cmd            = pipe[CTL_LO+3:CTL_LO]; // RULE16
  assign shift_link_enable       = pipe[BIT_SHIFT_EN] && pipe_advance;
  assign shift_ctrl              = pipe[CTL_LO+4:CTL_LO]; // RULE17

  assign test_output_enable = pipe[BIT_TEST_OE];
  assign test_code          = pipe[TEST_HI:TEST_LO];
  assign test_mux_sel       = pipe[TEST_LO+2:TEST_LO]; // RULE20
  // test bit 3 picks the status unit result over the selector
  assign seq_condition = test_output_enable &&
                         (pipe[TEST_LO+3] ? status_test_result :
                          test_mux_inputs[test_mux_sel]); // RULE19
  assign next_address_control = pipe[NAC_HI:NAC_LO]; // RULE21

  // wishbone slave, one wait state, ack pulse of one cycle
  assign wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o;

  always_ff @(posedge core_clk) begin
    if (rst) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= wb_req;
    end
  end

  // microword load wins over a software write in the same cycle
  always_ff @(posedge core_clk) begin
    if (rst) begin
      io_control <= IO_CTRL_RESET;
    end else if (io_control_load) begin
      io_control <= pipe[CTL_HI:CTL_LO]; // RULE14
    end else if (wb_req && wb_we_i && wb_adr_i == REG_IO_CTRL &&
                 wb_sel_i[0]) begin
      io_control <= wb_dat_i[7:0];
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      freeze <= 1'b0;
    end else if (wb_req && wb_we_i && wb_adr_i == REG_CONTROL &&
                 wb_sel_i[0]) begin
      freeze <= wb_dat_i[CTRL_FREEZE_BIT];
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      stall_count <= 32'h0000_0000;
    end else if (wb_req && wb_we_i && wb_adr_i == REG_STALL_CNT) begin
      stall_count <= 32'h0000_0000;
    end else if (stalled) begin
      stall_count <= stall_count + 32'h0000_0001;
    end
  end

  always_comb begin
    case (wb_adr_i)
      REG_STATUS:    next_dat = {28'h0000000, bus_state, stalled, freeze};
      REG_IO_CTRL:   next_dat = {24'h000000, io_control};
      REG_CONTROL:   next_dat = {31'h00000000, freeze};
      REG_STALL_CNT: next_dat = stall_count;
      default:       next_dat = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      wb_dat_o <= 32'h0000_0000;
    end else if (wb_req && !wb_we_i) begin
      wb_dat_o <= next_dat;
    end
  end

  // checks
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  a_status_word_drive: assert property ( // RULE1
    (!pipe[BIT_STATUS_N] && pipe[BIT_LITERAL_N]) |->
      (operand_bus == status_word && operand_bus_drive))
    else $error("status word not on operand bus");
  a_literal_drive: assert property ( // RULE12
    !pipe[BIT_LITERAL_N] |-> (operand_bus == pipe[LIT_HI:0]))
    else $error("literal not on operand bus");
  a_single_driver: assert property ( // RULE27
    !(!literal_to_operand_n && !status_word_to_operand_n))
    else $error("two operand bus drivers");
  a_stall_holds_pipe: assert property ( // RULE26
    stalled |=> $stable(pipe))
    else $error("pipeline moved while stalled");
  a_wait_after_req: assert property ( // RULE7
    (bus_state == BUS_IDLE && pipe[BIT_BUS_REQ] && pipe_advance) |=>
      (bus_state == BUS_WAIT && bus_request))
    else $error("bus request not tracked");
  a_no_mem_in_stall: assert property ( // RULE8
    stalled |-> !memory_request)
    else $error("memory request during stall");
  a_hold_keeps_req: assert property ( // RULE9
    (bus_state == BUS_GRANTED && !pipe[BIT_HOLD_N]) |-> bus_request)
    else $error("hold did not keep bus request");
  a_byte_lane: assert property ( // RULE11
    !pipe[BIT_WORD] |-> (mem_byte_hi_sel != mem_byte_lo_sel) &&
      (mem_byte_lo_sel == mem_addr_lsb))
    else $error("byte lane select wrong");
  a_pc_func_tie: assert property ( // RULE4
    pc_unit_func_bits[6] == pc_unit_func_bits[7] &&
      pc_unit_func_bits[8] == 1'b0 && pc_unit_func_bits[5:4] == 2'b00)
    else $error("pc unit tie bits wrong");
  a_io_load: assert property ( // RULE14
    io_control_load |=> io_control == $past(pipe[CTL_HI:CTL_LO]))
    else $error("io control not loaded");
  a_wb_ack_pulse: assert property (
    wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");

  c_bus_stall: cover property (bus_state == BUS_WAIT ##1 stalled[*2]
                               ##1 bus_ack);
  c_held_bus: cover property (bus_state == BUS_GRANTED && !bus_hold_n
                              ##1 bus_state == BUS_GRANTED);
  c_byte_write: cover property (memory_request && mem_write &&
                                !mem_word_not_byte);
  c_literal: cover property (!literal_to_operand_n && operand_bus_drive);
endmodule

// ### microword_control_decode_tb_top.sv
// self-checking bench for the microword control decoder
`timescale 1ns/1ps
module microword_control_decode_tb_top;
  import microword_pkg::*;
  typedef struct {string k; logic [31:0] e;} note_t;
  logic core_clk = 0, rst = 1, status_test_result = 0, status_carry = 0;
  logic carry_pass_in = 0, mem_addr_lsb = 0, bus_ack;
  logic wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0, wb_ack_o;
  logic [UW_WIDTH-1:0] microword_next = '0, w, r;
  logic [15:0] instr_reg = 16'h0000, status_word = 16'h0000;
  logic [15:0] operand_bus, seq_direct_in;
  logic [7:0]  test_mux_inputs = 8'h00, wb_adr_i = 8'h00, io_exp = 8'h00;
  logic [7:0]  io_control, shared_control_field;
  logic [3:0]  wb_sel_i = 4'h0, ack_delay = 4'h0;
  logic [31:0] wb_dat_i = 32'h0, wb_dat_o, rd, ex;
  logic pipe_advance, operand_bus_drive, status_word_to_operand_n;
  logic literal_to_operand_n, shift_count_to_sequencer_n, bus_request;
  logic branch_test_from_instr_n, bus_hold_n, memory_request, mem_write;
  logic mem_word_not_byte, mem_byte_hi_sel, mem_byte_lo_sel, alu_carry_in;
  logic upper_slices_enable, io_control_load, irq_recognition_disable;
  logic irq_ctrl_cmd_enable, shift_link_enable, test_output_enable;
  logic seq_condition;
  logic [3:0] status_test_sel, pc_unit_a_addr, pc_unit_b_addr, alu_a_addr;
  logic [3:0] alu_b_addr, irq_ctrl_cmd, next_address_control;
  logic [8:0] pc_unit_func_bits, alu_ctrl;
  logic [4:0] shift_ctrl;
  logic [5:0] test_code;
  logic [2:0] test_mux_sel;
  int seed = 73, err_total = 0, checks = 0, ticks = 0;
  note_t q[$];
  note_t n;
  microword_control_decode uut (.*);
  bus_ctrl_model partner (.core_clk(core_clk), .rst(rst),
    .bus_request(bus_request), .ack_delay(ack_delay), .bus_ack(bus_ack));
  always #10 core_clk = ~core_clk;
  function automatic logic [31:0] obs(string k);
    case (k)
      "operand_bus": return operand_bus;
      "drive": return operand_bus_drive;
      "status_n": return {literal_to_operand_n, status_word_to_operand_n};
      "seq_direct": return {shift_count_to_sequencer_n, seq_direct_in};
      "test_sel": return {branch_test_from_instr_n, status_test_sel};
      "pc_func": return pc_unit_func_bits;
      "pc_a": return pc_unit_a_addr;
      "pc_b": return pc_unit_b_addr;
      "alu_addr": return {alu_b_addr, alu_a_addr};
      "ctl_field": return shared_control_field;
      "irq": return {irq_recognition_disable, irq_ctrl_cmd_enable,
                     irq_ctrl_cmd};
      "shift": return {shift_link_enable, shift_ctrl};
      "nac": return next_address_control;
      "cond": return {test_output_enable, test_mux_sel, test_code,
                      seq_condition};
      "carry": return alu_carry_in;
      "upper": return upper_slices_enable;
      "byte_sel": return {mem_word_not_byte, mem_byte_hi_sel,
                          mem_byte_lo_sel};
      "io_load": return io_control_load;
      "io": return io_control;
      "bus_req": return {bus_request, bus_hold_n};
      "stall": return {pipe_advance, memory_request, mem_write};
      "alu_ctrl": return alu_ctrl;
      default: return 32'hDEAD;
    endcase
  endfunction
  function automatic logic [UW_WIDTH-1:0] idle();
    idle = '0;
    idle[ALU_CTRL_HI:ALU_CTRL_LO] = ALU_IDLE_CTRL;
    idle[BIT_STATUS_N] = 1'b1;
    idle[BIT_SHIFT_CNT_N] = 1'b1;
    idle[BIT_BR_TEST_N] = 1'b1;
    idle[BIT_HOLD_N] = 1'b1;
    idle[BIT_WORD] = 1'b1;
    idle[BIT_LITERAL_N] = 1'b1;
  endfunction
  task automatic note(string k, logic [31:0] e);
    q.push_back('{k, e});
  endtask
  task automatic cmp(string k, logic [31:0] e, logic [31:0] g);
    checks++;
    if (g !== e) begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", k, e, g);
    end
  endtask
  // register read data is the word taken at the acknowledge edge
  task automatic cmp_reg(logic [31:0] e, logic [31:0] g);
    checks++;
    if (g !== e) begin
      err_total++;
      $display("[FAIL] wb_dat expected %h seen %h", e, g);
    end
  endtask
  // watcher: notes made at a falling edge are judged at the next rising one
  always @(posedge core_clk) begin
    while (q.size() > 0) begin
      n = q.pop_front();
      if (n.k == "wb_dat") begin
        cmp_reg(n.e, rd);
      end else begin
        cmp(n.k, n.e, obs(n.k));
      end
    end
  end
  task automatic ld(logic [UW_WIDTH-1:0] a, logic [UW_WIDTH-1:0] b);
    @(posedge core_clk);
    r = {$random(seed), $random(seed), $random(seed)};
    microword_next <= a;
    {instr_reg, status_word, test_mux_inputs} <= r[39:0];
    {status_test_result, status_carry} <= r[43:42];
    {carry_pass_in, mem_addr_lsb} <= r[41:40];
    @(posedge core_clk);
    microword_next <= b;
    @(negedge core_clk);
  endtask
  task automatic wb(logic we, logic [7:0] a, logic [31:0] d);
    @(posedge core_clk);
    {wb_cyc_i, wb_stb_i, wb_we_i} <= {2'b11, we};
    {wb_adr_i, wb_sel_i, wb_dat_i} <= {a, 4'hF, d};
    do @(posedge core_clk); while (wb_ack_o !== 1'b1);
    rd = wb_dat_o;
    {wb_cyc_i, wb_stb_i} <= 2'b00;
    @(negedge core_clk);
  endtask
  task automatic end_sim();
    $display("checks %0d mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  always @(posedge core_clk) begin
    ticks <= ticks + 1;
    if (ticks == 4000) begin
      err_total++;
      end_sim();
    end
  end
  initial begin
    microword_next <= idle();
    repeat (20) @(posedge core_clk);
    rst <= 1'b0;
    @(negedge core_clk);
    note("drive", 0);
    note("bus_req", 2'b01);
    note("alu_ctrl", ALU_IDLE_CTRL);
    note("io", 0);
    for (int i = 0; i < 4; i++) begin
      w = idle();
      w[LIT_HI:0] = 16'($random(seed));
      {w[BIT_LITERAL_N], w[BIT_STATUS_N]} = i[1:0];
      ld(w, idle());
      ex = !i[1] ? w[15:0] : !i[0] ? status_word : 16'h0000;
      note("operand_bus", ex);
      note("drive", i != 3);
      note("status_n", {i[1], i != 2});
    end
    $display("test operand_bus done");
    for (int i = 0; i < 8; i++) begin
      w = {$random(seed), $random(seed), $random(seed)};
      w[ALU_CTRL_HI:ALU_CTRL_LO] = ALU_IDLE_CTRL;
      {w[BIT_BYTE_MODE], w[CARRY_HI:CARRY_LO]} = i[2:0];
      {w[BIT_BUS_REQ], w[BIT_MEM_REQ], w[BIT_HOLD_N]} = 3'b001;
      io_exp = w[BIT_IO_LOAD] ? w[CTL_HI:CTL_LO] : io_exp;
      ld(w, idle());
      ex = {w[66], w[66] ? w[15:0] : {12'h000, instr_reg[3:0]}};
      note("seq_direct", ex);
      note("test_sel", {w[65], w[65] ? w[23:20] : instr_reg[7:4]});
      note("pc_func", {1'b0, w[64], w[64], 2'b00, w[63:60]});
      note("pc_a", {1'b0, w[59:57]});
      note("pc_b", {1'b0, w[56:54]});
      note("alu_addr", w[47] ? w[42:35] : instr_reg[7:0]);
      note("ctl_field", w[42:35]);
      note("irq", {w[45], w[44], w[38:35]});
      note("shift", {w[43], w[39:35]});
      note("nac", w[19:16]);
      ex = {w[34], w[22:20], w[25:20], w[34] &
            (w[23] ? status_test_result : test_mux_inputs[w[22:20]])};
      note("cond", ex);
      ex = w[27] ? (w[26] ? status_carry : carry_pass_in) : w[26];
      note("carry", ex);
      note("upper", !w[90]);
      ex = {w[49], {2{!w[49]}} & {!mem_addr_lsb, mem_addr_lsb}};
      note("byte_sel", ex);
      note("io_load", w[46]);
      @(negedge core_clk);
      note("io", io_exp);
    end
    $display("test decode done");
    for (int d = 0; d < 2; d++) begin
      ack_delay <= d ? 4'h5 : 4'h0;
      w = idle();
      w[BIT_BUS_REQ] = 1'b1;
      r = idle();
      {r[BIT_MEM_REQ], r[BIT_WRITE], r[BIT_WORD]} = {1'b1, d[0], !d[0]};
      ld(w, r);
      note("bus_req", 2'b11);
      @(posedge core_clk);
      w = idle();
      w[BIT_HOLD_N] = !d[0];
      microword_next <= w;
      for (int k = 0; k < 20; k++) begin
        @(negedge core_clk);
        note("stall", {bus_ack, bus_ack, d[0]});
        if (bus_ack === 1'b1) break;
      end
      @(negedge core_clk);
      note("bus_req", {d[0], !d[0]});
      ld(idle(), idle());
      note("bus_req", 2'b01);
    end
    $display("test bus done");
    wb(0, REG_STATUS, 0);
    note("wb_dat", 0);
    wb(0, REG_IO_CTRL, 0);
    note("wb_dat", io_exp);
    io_exp = 8'($random(seed));
    wb(1, REG_IO_CTRL, {24'h0, io_exp});
    wb(0, REG_IO_CTRL, 0);
    note("wb_dat", io_exp);
    note("io", io_exp);
    // one stalled cycle per cycle of partner delay in the second bus test
    wb(0, REG_STALL_CNT, 0);
    note("wb_dat", 32'h0000_0005);
    wb(1, REG_STALL_CNT, 0);
    wb(0, REG_STALL_CNT, 32'hFFFFFFFF);
    note("wb_dat", 0);
    wb(1, REG_CONTROL, 32'h0000_0001);
    wb(0, REG_STATUS, 0);
    note("wb_dat", 32'h0000_0001);
    note("stall", 0);
    wb(0, 8'h10, 0);
    note("wb_dat", 0);
    wb(1, REG_CONTROL, 0);
    @(negedge core_clk);
    $display("test registers done");
    end_sim();
  end
endmodule

// ### microword_pkg.sv
// shared constants for the microword control decoder
package microword_pkg;
  localparam int UW_WIDTH          = 96;
  localparam int BIT_BYTE_MODE     = 90;
  localparam int ALU_CTRL_HI       = 86;
  localparam int ALU_CTRL_LO       = 78;
  localparam int BIT_STATUS_N      = 67;
  localparam int BIT_SHIFT_CNT_N   = 66;
  localparam int BIT_BR_TEST_N     = 65;
  localparam int PCU_FUNC_HI       = 64;
  localparam int PCU_FUNC_LO       = 60;
  localparam int PCU_A_HI          = 59;
  localparam int PCU_A_LO          = 57;
  localparam int PCU_B_HI          = 56;
  localparam int PCU_B_LO          = 54;
  localparam int BIT_BUS_REQ       = 53;
  localparam int BIT_MEM_REQ       = 52;
  localparam int BIT_HOLD_N        = 51;
  localparam int BIT_WRITE         = 50;
  localparam int BIT_WORD          = 49;
  localparam int BIT_LITERAL_N     = 48;
  localparam int BIT_ADDR_FROM_ROM = 47;
  localparam int BIT_IO_LOAD       = 46;
  localparam int BIT_IRQ_DIS       = 45;
  localparam int BIT_IRQ_CMD       = 44;
  localparam int BIT_SHIFT_EN      = 43;
  localparam int CTL_HI            = 42;
  localparam int CTL_LO            = 35;
  localparam int BIT_TEST_OE       = 34;
  localparam int CARRY_HI          = 27;
  localparam int CARRY_LO          = 26;
  localparam int TEST_HI           = 25;
  localparam int TEST_LO           = 20;
  localparam int NAC_HI            = 19;
  localparam int NAC_LO            = 16;
  localparam int LIT_HI            = 15;
  // ALU field at reset: destination Y bus only, function forces zero
  localparam logic [8:0] ALU_IDLE_CTRL = 9'h180;
  // wishbone register byte offsets
  localparam logic [7:0] REG_STATUS    = 8'h00;
  localparam logic [7:0] REG_IO_CTRL   = 8'h04;
  localparam logic [7:0] REG_CONTROL   = 8'h08;
  localparam logic [7:0] REG_STALL_CNT = 8'h0C;
  localparam logic [7:0] IO_CTRL_RESET = 8'h00;
  localparam int CTRL_FREEZE_BIT       = 0;
  // carry-in select codes
  localparam logic [1:0] CARRY_ZERO    = 2'h0;
  localparam logic [1:0] CARRY_ONE     = 2'h1;
  localparam logic [1:0] CARRY_PASS    = 2'h2;
  localparam logic [1:0] CARRY_STATUS  = 2'h3;
  typedef enum logic [1:0] {
    BUS_IDLE    = 2'b00,
    BUS_WAIT    = 2'b01,
    BUS_GRANTED = 2'b11
  } bus_state_t;
endpackage
